// file: ftfc_chk.sv
/*
 * Port checker for the flash timing and fault control block.
 * Assumes it is bound to the top module and sees its ports only.
 */
`timescale 1ns/10ps
`default_nettype none
module ftfc_chk #(
    parameter int GUARD_CYC = 1000
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_chip_wake,
    input wire logic i_overvolt_det,
    input wire logic o_flash_on,
    input wire logic o_torch_on,
    input wire logic [4:0] o_main_code,
    input wire logic o_main_ext_res,
    input wire logic o_pilot_on,
    input wire logic [2:0] o_pilot_code,
    input wire logic o_switch_inhibit,
    input wire logic o_irq_n_o,
    input wire logic o_irq_n_oe
);
    logic [31:0] flash_run_q;
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flash_run_q <= '0;
        end else begin
            flash_run_q <= o_flash_on ? flash_run_q + 32'h1 : '0;
        end
    end
    default clocking dc @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    chk_rdata_quiet: assert property (
        !$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    chk_flash_armed: assert property (
        $rose(o_flash_on) |-> o_main_ext_res || o_main_code >= 5'h0c)
        else $error("flash without armed code");
    chk_torch_code: assert property (
        o_torch_on && !o_main_ext_res |-> o_main_code inside {[1:11]})
        else $error("torch with wrong code");
    chk_pilot_code: assert property (
        o_pilot_on && !o_main_ext_res |-> o_pilot_code != 3'h0)
        else $error("pilot on with zero code");
    chk_irq_pulls_low: assert property (
        o_irq_n_oe |-> !o_irq_n_o)
        else $error("interrupt driven high");
    chk_fault_dark: assert property (
        o_irq_n_oe && $past(o_irq_n_oe) |->
        !o_flash_on && !o_torch_on && !o_pilot_on && o_switch_inhibit)
        else $error("leds on while faulted");
    chk_sleep_dark: assert property (
        (!i_chip_wake) [*8] |->
        !o_flash_on && !o_torch_on && !o_pilot_on && o_switch_inhibit)
        else $error("leds on while asleep");
    chk_ovp_irq: assert property (
        (i_overvolt_det && i_chip_wake) [*8] |-> ##[0:4] o_irq_n_oe)
        else $error("overvoltage without interrupt");
    chk_guard_bound: assert property (
        flash_run_q <= 32'(GUARD_CYC + 4))
        else $error("flash beyond guard time");
endmodule : ftfc_chk
bind ftfc_flash_timing_fault_control ftfc_chk #(.GUARD_CYC(GUARD_CYC)) u_chk (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_chip_wake(i_chip_wake),
    .i_overvolt_det(i_overvolt_det), .o_flash_on(o_flash_on),
    .o_torch_on(o_torch_on), .o_main_code(o_main_code),
    .o_main_ext_res(o_main_ext_res), .o_pilot_on(o_pilot_on),
    .o_pilot_code(o_pilot_code), .o_switch_inhibit(o_switch_inhibit),
    .o_irq_n_o(o_irq_n_o), .o_irq_n_oe(o_irq_n_oe)
);
`default_nettype wire

// file: ftfc_flash_timing_fault_control.sv
/*
 * Flash arming, triggering, timing and fault flag logic of an LED flash
 * driver. Assumes a plain register port from a serial-bus slave on the
 * same clock; pins and analog fault comparators arrive asynchronously.
 */
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Armed flash starts on pin or bit
// - Direct flash held by enables, 820 ms cap
// - Timed flash only serial, select bit
// - Timer starts at trigger edge
// - Timed flash ignores strobe length
// - Duration is 820 ms minus code steps
// - Normal timed end raises nothing
// - Retrigger allowed right after end
// - Serial pilot current from 3-bit code
// - Faults inhibit, flag status, pull interrupt
// - Direct mode still drives interrupt
// - Fault cuts main and pilot at once
// - Serial clear by writing 00h
// - Fault touches only status, not current or timer
// - Direct clear by both enables low
// - Overvoltage sets status bit 0
// - Untimed flash guarded at 820 ms
// - Strobe low clears software trigger bit
// - Enable A falling resets guard timer
// - Guard expiry sets status bit 1
// - Overheat inhibits until cooled and cleared, bit 2
// - Output short sets status bit 3
// - Wake low shuts down everything
module ftfc_flash_timing_fault_control #(
    parameter int GUARD_CYC = ftfc_pkg::FTFC_GUARD_CYC,
    parameter int STEP_CYC = ftfc_pkg::FTFC_STEP_CYC
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Register port
    input wire logic [1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    // Pins
    input wire logic i_chip_wake,
    input wire logic i_if_direct,
    input wire logic i_hw_flash_trigger_pin,
    input wire logic i_enable_line_a,
    input wire logic i_enable_line_b,
    // Fault detectors
    input wire logic i_overvolt_det,
    input wire logic i_overheat_det,
    input wire logic i_short_det,
    // LED and converter controls
    output logic o_flash_on,
    output logic o_torch_on,
    output logic [4:0] o_main_code,
    output logic o_main_ext_res,
    output logic o_pilot_on,
    output logic [2:0] o_pilot_code,
    output logic o_switch_inhibit,
    // Open-drain interrupt, active low
    output logic o_irq_n_o,
    output logic o_irq_n_oe
);
    import ftfc_pkg::*;

    localparam int NSYNC = 8;

    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    function automatic logic [FTFC_CNT_W-1:0] flash_limit(
        input logic [3:0] code
    );
        logic [FTFC_CNT_W-1:0] step;
        step = FTFC_CNT_W'(STEP_CYC) * FTFC_CNT_W'(code);
        flash_limit = FTFC_CNT_W'(GUARD_CYC) - step;
    endfunction : flash_limit

    //------------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------------
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync_a_q;
    logic [NSYNC-1:0] sync_b_q;
    logic [NSYNC-1:0] sync_c_q;
    logic [NSYNC-1:0] pin_q;
    logic [NSYNC-1:0] pin_prev_q;

    assign pin_raw = {i_if_direct, i_short_det, i_overheat_det,
                      i_overvolt_det, i_enable_line_b, i_enable_line_a,
                      i_hw_flash_trigger_pin, i_chip_wake};

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_a_q <= '0;
            sync_b_q <= '0;
            sync_c_q <= '0;
        end else begin
            sync_a_q <= pin_raw;
            sync_b_q <= sync_a_q;
            sync_c_q <= sync_b_q;
        end
    end

    // A change counts once the second and third stage agree
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_q <= '0;
            pin_prev_q <= '0;
        end else begin
            for (int i = 0; i < NSYNC; i++) begin
                if (sync_b_q[i] == sync_c_q[i]) begin
                    pin_q[i] <= sync_c_q[i];
                end
            end
            pin_prev_q <= pin_q;
        end
    end

    logic wake;
    logic hw_trig;
    logic en_a;
    logic en_b;
    logic hw_rise;
    logic hw_fall;
    logic en_a_fall;
    logic wake_rise;

    assign wake = pin_q[0];
    assign hw_trig = pin_q[1];
    assign en_a = pin_q[2];
    assign en_b = pin_q[3];
    assign hw_rise = pin_q[1] & ~pin_prev_q[1];
    assign hw_fall = ~pin_q[1] & pin_prev_q[1];
    assign en_a_fall = ~pin_q[2] & pin_prev_q[2];
    assign wake_rise = pin_q[0] & ~pin_prev_q[0];

    //------------------------------------------------------------------
    // Interface mode, caught as the device wakes
    //------------------------------------------------------------------
    logic direct_q;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            direct_q <= 1'b0;
        end else begin
            if (wake_rise) begin
                direct_q <= pin_q[7];
            end
        end
    end

    //------------------------------------------------------------------
    // Registers
    //------------------------------------------------------------------
    logic [7:0] curr_q;
    logic [7:0] timer_q;
    logic sw_trig_q;
    logic sw_trig_prev_q;
    logic [3:0] status_q;
    logic [3:0] fault_set;
    logic fault_clr;
    logic flash_end;
    logic wr_curr;
    logic wr_hw_flash_trigger_pin;

    assign wr_curr = i_reg_wr && i_reg_addr == FTFC_ADDR_CURR;
    assign wr_hw_flash_trigger_pin = i_reg_wr && i_reg_addr == FTFC_ADDR_HW_FLASH_TRIGGER_PIN;

    // Fault leaves these untouched; only host writes and wake low change them
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            curr_q <= FTFC_RST_REG;
            timer_q <= FTFC_RST_REG;
        end else if (!wake) begin
            curr_q <= FTFC_RST_REG;
            timer_q <= FTFC_RST_REG;
        end else if (i_reg_wr) begin
            if (i_reg_addr == FTFC_ADDR_CURR) begin
                curr_q <= i_reg_wdata;
            end
            if (i_reg_addr == FTFC_ADDR_TIMER) begin
                timer_q <= i_reg_wdata;
            end
        end
    end

    // Software trigger bit; strobe low or flash end clears it
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sw_trig_q <= 1'b0;
            sw_trig_prev_q <= 1'b0;
        end else begin
            sw_trig_prev_q <= sw_trig_q;
            if (!wake || direct_q) begin
                sw_trig_q <= 1'b0;
            end else if (wr_hw_flash_trigger_pin) begin
                sw_trig_q <= i_reg_wdata[FTFC_SWTRIG_BIT];
            end else if (hw_fall || flash_end) begin
                sw_trig_q <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------------
    // Fault flags
    //------------------------------------------------------------------
    logic guard_hit;

    always_comb begin
        fault_set = '0;
        fault_set[FTFC_ST_OVP] = pin_q[4];
        fault_set[FTFC_ST_GUARD] = guard_hit;
        fault_set[FTFC_ST_OT] = pin_q[5];
        fault_set[FTFC_ST_SHORT] = pin_q[6];
    end

    // Serial: write 00h to current control; direct: both enables low
    assign fault_clr = direct_q ? (~en_a & ~en_b)
                     : (wr_curr && i_reg_wdata == FTFC_CLEAR_CODE);

    // Set wins over clear; flags stay until cleared
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            status_q <= '0;
        end else if (!wake) begin
            status_q <= '0;
        end else begin
            status_q <= (fault_clr ? 4'h0 : status_q) | fault_set;
        end
    end

    logic faulted;
    assign faulted = |status_q;

    //------------------------------------------------------------------
    // Flash state and timers
    //------------------------------------------------------------------
    ftfc_state_e state_q;
    logic [FTFC_CNT_W-1:0] cnt_q;
    logic [FTFC_CNT_W-1:0] limit_q;
    logic timed_q;
    logic armed;
    logic sw_rise;
    logic trig;
    logic hold_lvl;
    logic timed_sel;

    assign timed_sel = timer_q[FTFC_TSEL_BIT] & ~direct_q;
    assign armed = curr_q[7:FTFC_MAIN_LSB] >= FTFC_FLASH_MIN;
    assign sw_rise = sw_trig_q & ~sw_trig_prev_q;
    assign trig = direct_q ? (en_a & en_b)
                : armed & (hw_rise | sw_rise);
    assign hold_lvl = direct_q ? (en_a & en_b) : (hw_trig | sw_trig_q);
    assign guard_hit = state_q == FTFC_FLASH && !timed_q
                    && cnt_q == limit_q - FTFC_CNT_W'(1);
    assign flash_end = state_q == FTFC_FLASH
                    && cnt_q == limit_q - FTFC_CNT_W'(1);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= FTFC_IDLE;
            cnt_q <= '0;
            limit_q <= '0;
            timed_q <= 1'b0;
        end else if (!wake || faulted) begin
            state_q <= FTFC_IDLE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                FTFC_IDLE: begin
                    cnt_q <= '0;
                    if (trig) begin
                        state_q <= FTFC_FLASH;
                        timed_q <= timed_sel;
                        limit_q <= timed_sel
                            ? flash_limit(timer_q[3:0])
                            : FTFC_CNT_W'(GUARD_CYC);
                    end
                end
                FTFC_FLASH: begin
                    cnt_q <= cnt_q + FTFC_CNT_W'(1);
                    if (flash_end) begin
                        // Timed end is silent; untimed end raises guard
                        state_q <= timed_q ? FTFC_IDLE : FTFC_HOLD;
                    end else if (!timed_q && !hold_lvl) begin
                        state_q <= FTFC_IDLE;
                    end else if (direct_q && en_a_fall) begin
                        state_q <= FTFC_IDLE;
                    end
                end
                FTFC_HOLD: begin
                    state_q <= FTFC_IDLE;
                end
                default: begin
                    state_q <= FTFC_IDLE;
                end
            endcase
        end
    end

    //------------------------------------------------------------------
    // LED and converter outputs
    //------------------------------------------------------------------
    logic flash_d;
    logic torch_d;
    logic pilot_d;
    logic inhibit_d;

    assign inhibit_d = faulted | pin_q[5] | !wake;
    assign flash_d = state_q == FTFC_FLASH && !inhibit_d;
    always_comb begin
        if (inhibit_d) begin
            torch_d = 1'b0;
            pilot_d = 1'b0;
        end else if (direct_q) begin
            torch_d = en_b & ~en_a;
            pilot_d = en_a & ~en_b;
        end else begin
            torch_d = !flash_d && curr_q[7:FTFC_MAIN_LSB] != FTFC_MAIN_OFF
                      && !armed;
            pilot_d = curr_q[2:0] != 3'h0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_flash_on <= 1'b0;
            o_torch_on <= 1'b0;
            o_main_code <= '0;
            o_main_ext_res <= 1'b0;
            o_pilot_on <= 1'b0;
            o_pilot_code <= '0;
            o_switch_inhibit <= 1'b1;
            o_irq_n_oe <= 1'b0;
        end else begin
            o_flash_on <= flash_d;
            o_torch_on <= torch_d;
            o_main_code <= direct_q ? FTFC_MAIN_OFF : curr_q[7:FTFC_MAIN_LSB];
            o_main_ext_res <= direct_q;
            o_pilot_on <= pilot_d;
            o_pilot_code <= direct_q ? 3'h0 : curr_q[2:0];
            o_switch_inhibit <= inhibit_d;
            o_irq_n_oe <= faulted;
        end
    end

    assign o_irq_n_o = 1'b0;

    //------------------------------------------------------------------
    // Register read port
    //------------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata <= '0;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                FTFC_ADDR_CURR: o_reg_rdata <= curr_q;
                FTFC_ADDR_TIMER: o_reg_rdata <= timer_q;
                FTFC_ADDR_HW_FLASH_TRIGGER_PIN: o_reg_rdata <= {7'h00, sw_trig_q};
                FTFC_ADDR_STAT: begin
                    o_reg_rdata <= direct_q ? 8'h00 : {4'h0, status_q};
                end
                default: o_reg_rdata <= '0;
            endcase
        end else begin
            o_reg_rdata <= '0;
        end
    end

endmodule : ftfc_flash_timing_fault_control

`default_nettype wire

// file: ftfc_host.sv
/*
 * Host model for the strobe pin and the two enable pins.
 * Assumes the bench calls its tasks; pins change after a clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module ftfc_host (
    // Clock
    input wire logic i_clk,
    // Pins towards the device
    output logic o_trig,
    output logic o_ena,
    output logic o_enb
);
    initial begin
        o_trig = 1'b0;
        o_ena = 1'b0;
        o_enb = 1'b0;
    end
    task automatic pulse(input int n);
        @(posedge i_clk);
        o_trig <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_trig <= 1'b0;
    endtask : pulse
    // Both low clears a fault in direct mode
    task automatic en(input logic a, input logic b);
        @(posedge i_clk);
        o_ena <= a;
        o_enb <= b;
    endtask : en
endmodule : ftfc_host
`default_nettype wire

// file: ftfc_pkg.sv
/*
 * Constants shared by the flash timing and fault control block.
 * Assumes a 125 MHz core clock.
 */
package ftfc_pkg;
    // Register offsets
    localparam logic [1:0] FTFC_ADDR_CURR = 2'h0;
    localparam logic [1:0] FTFC_ADDR_TIMER = 2'h1;
    localparam logic [1:0] FTFC_ADDR_HW_FLASH_TRIGGER_PIN = 2'h2;
    localparam logic [1:0] FTFC_ADDR_STAT = 2'h3;
    // Field positions
    localparam int FTFC_MAIN_LSB = 3;
    localparam int FTFC_TSEL_BIT = 4;
    localparam int FTFC_SWTRIG_BIT = 0;
    localparam int FTFC_ST_OVP = 0;
    localparam int FTFC_ST_GUARD = 1;
    localparam int FTFC_ST_OT = 2;
    localparam int FTFC_ST_SHORT = 3;
    // Values
    localparam logic [7:0] FTFC_RST_REG = 8'h00;
    localparam logic [7:0] FTFC_CLEAR_CODE = 8'h00;
    localparam logic [4:0] FTFC_FLASH_MIN = 5'h0c;
    localparam logic [4:0] FTFC_MAIN_OFF = 5'h00;
    // Timing
    localparam int FTFC_CLK_KHZ = 125000;
    localparam int FTFC_GUARD_US = 820000;
    localparam int FTFC_STEP_US = 54600;
    localparam int FTFC_GUARD_CYC = FTFC_GUARD_US / 1000 * FTFC_CLK_KHZ;
    localparam int FTFC_STEP_CYC = FTFC_STEP_US * (FTFC_CLK_KHZ / 1000);
    localparam int FTFC_CNT_W = 27;
    // Flash state
    typedef enum logic [1:0] {
        FTFC_IDLE,
        FTFC_FLASH,
        FTFC_HOLD
    } ftfc_state_e;
endpackage : ftfc_pkg

// file: testbench.sv
/*
 * Self-checking bench for the flash timing and fault control block.
 * Assumes the host model drives the strobe and enable pins.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ftfc_pkg::*;
    localparam int GUARD = 1000;
    localparam int STEP = 60;
    logic clk, nrst, wr, rd, wake, dir, trig, ena, enb;
    logic flash, torch, ext, pil, inh, irq_o, irq_oe;
    logic [1:0] addr;
    logic [7:0] wdata, rdata;
    logic [2:0] fd, pcode;
    logic [4:0] mcode;
    int fail_count, n_tests;
    ftfc_flash_timing_fault_control #(.GUARD_CYC(GUARD), .STEP_CYC(STEP)) uut (
        .i_core_clk(clk), .i_nrst(nrst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_chip_wake(wake), .i_if_direct(dir),
        .i_hw_flash_trigger_pin(trig), .i_enable_line_a(ena),
        .i_enable_line_b(enb), .i_overvolt_det(fd[0]),
        .i_overheat_det(fd[1]), .i_short_det(fd[2]), .o_flash_on(flash),
        .o_torch_on(torch), .o_main_code(mcode), .o_main_ext_res(ext),
        .o_pilot_on(pil), .o_pilot_code(pcode), .o_switch_inhibit(inh),
        .o_irq_n_o(irq_o), .o_irq_n_oe(irq_oe)
    );
    ftfc_host u_host (.i_clk(clk), .o_trig(trig), .o_ena(ena), .o_enb(enb));
    task automatic close_out();
        if (fail_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_near(input int got, input int exp);
        n_tests++;
        if (got < exp - 4 || got > exp + 4) begin
            fail_count++;
            $display("MISMATCH t=%0t cycles %0d exp %0d", $time, got, exp);
        end
    endtask : cmp_near
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmp(32'(rdata), 32'(exp));
    endtask : rd_reg
    task automatic wait_flash(input logic lvl, output int n);
        n = 0;
        while (flash !== lvl) begin
            @(posedge clk);
            #1 n++;
            if (n > 3000) begin
                fail_count++;
                $display("MISMATCH t=%0t flash wait timed out", $time);
                close_out();
            end
        end
    endtask : wait_flash
    task automatic s_timed();
        int n;
        wr_reg(FTFC_ADDR_TIMER, 8'h13);
        wr_reg(FTFC_ADDR_CURR, 8'h63);
        wr_reg(FTFC_ADDR_HW_FLASH_TRIGGER_PIN, 8'h01);
        wait_flash(1'b1, n);
        cmp(32'(pcode), 32'h3);
        cmp(32'({ext, mcode}), 32'h0c);
        wait_flash(1'b0, n);
        cmp_near(n, GUARD - 3 * STEP);
        cmp(32'(irq_oe), 32'h0);
        rd_reg(FTFC_ADDR_STAT, 8'h00);
        wr_reg(FTFC_ADDR_HW_FLASH_TRIGGER_PIN, 8'h01);
        wait_flash(1'b1, n);
        cmp_near(n, 3);
        wait_flash(1'b0, n);
        fork
            u_host.pulse(40);
        join_none
        wait_flash(1'b1, n);
        wait_flash(1'b0, n);
        cmp_near(n, GUARD - 3 * STEP);
    endtask : s_timed
    task automatic s_guard();
        int n;
        wr_reg(FTFC_ADDR_TIMER, 8'h05);
        wr_reg(FTFC_ADDR_HW_FLASH_TRIGGER_PIN, 8'h01);
        wait_flash(1'b1, n);
        wait_flash(1'b0, n);
        cmp_near(n, GUARD);
        repeat (2) @(posedge clk);
        #1 cmp(32'({irq_oe, irq_o, inh, pil}), 32'ha);
        rd_reg(FTFC_ADDR_STAT, 8'h02);
        rd_reg(FTFC_ADDR_TIMER, 8'h05);
        wr_reg(FTFC_ADDR_CURR, FTFC_CLEAR_CODE);
        repeat (2) @(posedge clk);
        #1 cmp(32'(irq_oe), 32'h0);
        rd_reg(FTFC_ADDR_STAT, 8'h00);
        wr_reg(FTFC_ADDR_CURR, 8'h10);
        repeat (2) @(posedge clk);
        #1 cmp(32'({torch, ext, mcode}), 32'h42);
        wr_reg(FTFC_ADDR_HW_FLASH_TRIGGER_PIN, 8'h01);
        rd_reg(FTFC_ADDR_HW_FLASH_TRIGGER_PIN, 8'h01);
        u_host.pulse(20);
        repeat (8) @(posedge clk);
        rd_reg(FTFC_ADDR_HW_FLASH_TRIGGER_PIN, 8'h00);
    endtask : s_guard
    task automatic s_faults();
        logic [7:0] bits [3] = '{8'h01, 8'h04, 8'h08};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            fd <= 3'(1 << i);
            repeat (20) @(posedge clk);
            fd <= 3'h0;
            repeat (10) @(posedge clk);
            #1 cmp(32'({irq_oe, inh}), 32'h3);
            rd_reg(FTFC_ADDR_STAT, bits[i]);
            wr_reg(FTFC_ADDR_CURR, FTFC_CLEAR_CODE);
            repeat (2) @(posedge clk);
            #1 cmp(32'({irq_oe, inh}), 32'h0);
        end
    endtask : s_faults
    task automatic s_direct();
        int n;
        @(posedge clk);
        wake <= 1'b0;
        repeat (10) @(posedge clk);
        dir <= 1'b1;
        repeat (2) @(posedge clk);
        wake <= 1'b1;
        repeat (10) @(posedge clk);
        rd_reg(FTFC_ADDR_TIMER, FTFC_RST_REG);
        u_host.en(1'b1, 1'b1);
        wait_flash(1'b1, n);
        repeat (500) @(posedge clk);
        u_host.en(1'b0, 1'b1);
        wait_flash(1'b0, n);
        cmp_near(n, 5);
        cmp(32'({torch, ext, mcode}), 32'h60);
        u_host.en(1'b1, 1'b1);
        wait_flash(1'b1, n);
        wait_flash(1'b0, n);
        cmp_near(n, GUARD);
        repeat (2) @(posedge clk);
        #1 cmp(32'(irq_oe), 32'h1);
        rd_reg(FTFC_ADDR_STAT, 8'h00);
        u_host.en(1'b0, 1'b0);
        repeat (10) @(posedge clk);
        #1 cmp(32'(irq_oe), 32'h0);
    endtask : s_direct
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        nrst = 1'b0;
        {wr, rd, wake, dir, addr, wdata, fd} = '0;
        fail_count = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        wake <= 1'b1;
        repeat (10) @(posedge clk);
        rd_reg(FTFC_ADDR_CURR, FTFC_RST_REG);
        s_timed();
        s_guard();
        s_faults();
        s_direct();
        close_out();
    end
endmodule : testbench
`default_nettype wire
